// File: logic/hbe_pkg.sv
// package of constants for the link-B error-reporting register bank
// Overview of operation
// - command bit 8 gates system-error messages globally
// - status bit 14 flags message sent, write-one clears
// - other status bits read-only, read zero
// - first-error register holds at most one first flag
// - errors while first is held go to next
// - error flags clear only where one is written
// - flag 6 marks system error received from partner
// - flag 5 marks master-aborted invalid address request
// - flag 4 marks own cycle ended by target abort
// - flags 3,2 mark correctable header, data errors
// - flags 1,0 mark uncorrectable header, data errors
// - subsystem vendor identifier writable once only
// - subsystem identifier writable once only
// - header type reads 00h or 80h, no storage
// - class constants: base FFh, sub-class 00h
// - vendor and device identifiers read-only constants
// - revision identifier read-only, matches function zero
// - next-error register may hold several flags
// - enabled flags raise system-error, SMI or SCI messages
package hbe_pkg;

    // ==========================================================
    // configuration offsets (byte addresses)
    localparam logic [7:0] OFF_VENDOR_IDENT   = 8'h00;
    localparam logic [7:0] OFF_DEVICE_IDENT   = 8'h02;
    localparam logic [7:0] OFF_COMMAND        = 8'h04;
    localparam logic [7:0] OFF_STATUS         = 8'h06;
    localparam logic [7:0] OFF_REVISION_IDENT = 8'h08;
    localparam logic [7:0] OFF_SUB_CLASS      = 8'h0A;
    localparam logic [7:0] OFF_BASE_CLASS     = 8'h0B;
    localparam logic [7:0] OFF_HEADER_TYPE    = 8'h0E;
    localparam logic [7:0] OFF_SUBSYS_VENDOR  = 8'h2C;
    localparam logic [7:0] OFF_SUBSYS_IDENT   = 8'h2E;
    localparam logic [7:0] OFF_FIRST_ERROR    = 8'h80;
    localparam logic [7:0] OFF_NEXT_ERROR     = 8'h82;
    localparam logic [7:0] OFF_SYSERR_EN      = 8'hA0;
    localparam logic [7:0] OFF_SMI_EN         = 8'hA2;
    localparam logic [7:0] OFF_SCI_EN         = 8'hA4;

    // ==========================================================
    // field positions and widths
    localparam int         POS_GLOBAL_SYSERR  = 8;
    localparam int         POS_SIGNALED_SERR  = 14;
    localparam int         NUM_FLAGS          = 7;
    localparam logic [6:0] SYSERR_EN_MASK     = 7'h3F;

    // ==========================================================
    // constant field values
    localparam logic [7:0] SUB_CLASS_VALUE    = 8'h00;
    localparam logic [7:0] BASE_CLASS_VALUE   = 8'hFF;
    localparam logic [7:0] HDR_SINGLE         = 8'h00;
    localparam logic [7:0] HDR_MULTI          = 8'h80;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_SUBSYS        = 16'h0000;
    localparam logic [6:0]  RST_FLAGS         = 7'h00;
    localparam logic [31:0] RST_RDATA         = 32'h0000_0000;

endpackage

// File: logic/hbe_regs.sv
// link-B error-reporting configuration register bank
`timescale 1ns/1ps
module hbe_regs
    import hbe_pkg::*;
#(
    parameter logic [15:0] VENDOR_IDENT   = 16'h1234,  // arbitrary value
    parameter logic [15:0] DEVICE_IDENT   = 16'h5678,  // arbitrary value
    parameter logic [7:0]  REVISION_IDENT = 8'h01,     // arbitrary value
    parameter bit          MULTI_FUNCTION = 1'b1
) (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // configuration access, dword addressed
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:2]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_rvalid,
    // link-B fault pulses, bit n sets flag n
    input  wire logic [6:0]  err_event,
    // message requests toward the primary link
    output logic             syserr_msg,
    output logic             smi_msg,
    output logic             sci_msg
);

    // ==========================================================
    // state
    typedef struct packed {
        logic        global_syserr;
        logic        signaled_syserr;
        logic [15:0] subsys_vendor;
        logic        vendor_locked;
        logic [15:0] subsys_ident;
        logic        ident_locked;
        logic [6:0]  first_err;
        logic [6:0]  next_err;
        logic [6:0]  syserr_en;
        logic [6:0]  smi_en;
        logic [6:0]  sci_en;
        logic [31:0] rdata;
        logic        rvalid;
        logic        syserr_msg;
        logic        smi_msg;
        logic        sci_msg;
    } hbe_state_t;

    hbe_state_t st;
    hbe_state_t next_st;

    // keeps the highest set bit only
    function automatic logic [6:0] hbe_pick_one(input logic [6:0] v);
        logic [6:0] r;
        r = '0;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic hbe_hit(input logic [7:2] a, input logic [7:0] off);
        return a == off[7:2];
    endfunction

    // ==========================================================
    // read mux
    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        if (hbe_hit(cfg_addr, OFF_VENDOR_IDENT))
            rd_word = {DEVICE_IDENT, VENDOR_IDENT};
        else if (hbe_hit(cfg_addr, OFF_COMMAND)) begin
            rd_word[16 + POS_SIGNALED_SERR] = st.signaled_syserr;
            rd_word[POS_GLOBAL_SYSERR]      = st.global_syserr;
        end
        else if (hbe_hit(cfg_addr, OFF_REVISION_IDENT))
            rd_word = {BASE_CLASS_VALUE, SUB_CLASS_VALUE, 8'h00, REVISION_IDENT};
        else if (hbe_hit(cfg_addr, OFF_HEADER_TYPE))
            rd_word[23:16] = MULTI_FUNCTION ? HDR_MULTI : HDR_SINGLE;
        else if (hbe_hit(cfg_addr, OFF_SUBSYS_VENDOR))
            rd_word = {st.subsys_ident, st.subsys_vendor};
        else if (hbe_hit(cfg_addr, OFF_FIRST_ERROR))
            rd_word = {9'h000, st.next_err, 9'h000, st.first_err};
        else if (hbe_hit(cfg_addr, OFF_SYSERR_EN))
            rd_word = {9'h000, st.smi_en, 9'h000, st.syserr_en};
        else if (hbe_hit(cfg_addr, OFF_SCI_EN))
            rd_word = {25'h000_0000, st.sci_en};
    end

    // ==========================================================
    // next state
    logic [6:0] clr_first;
    logic [6:0] clr_next;
    logic [6:0] set_first;
    logic [6:0] set_next;
    logic [6:0] new_flags;
    logic       wr_cmd;
    logic       wr_err;
    logic       wr_en0;
    logic       wr_sub;

    always_comb begin
        next_st   = st;
        wr_cmd    = cfg_wr && hbe_hit(cfg_addr, OFF_COMMAND);
        wr_err    = cfg_wr && hbe_hit(cfg_addr, OFF_FIRST_ERROR);
        wr_en0    = cfg_wr && hbe_hit(cfg_addr, OFF_SYSERR_EN);
        wr_sub    = cfg_wr && hbe_hit(cfg_addr, OFF_SUBSYS_VENDOR);
        clr_first = (wr_err && cfg_be[0]) ? cfg_wdata[6:0] : 7'h00;
        clr_next  = (wr_err && cfg_be[2]) ? cfg_wdata[22:16] : 7'h00;

        // a flag already held in first sends everything to next
        if (st.first_err == RST_FLAGS) begin
            set_first = hbe_pick_one(err_event);
            set_next  = err_event & ~set_first;
        end else begin
            set_first = '0;
            set_next  = err_event;
        end
        new_flags = set_first | set_next;

        // set wins over a simultaneous clear
        next_st.first_err = (st.first_err & ~clr_first) | set_first;
        next_st.next_err  = (st.next_err & ~clr_next) | set_next;

        if (wr_cmd && cfg_be[1])
            next_st.global_syserr = cfg_wdata[POS_GLOBAL_SYSERR];
        if (wr_en0 && cfg_be[0])
            next_st.syserr_en = cfg_wdata[6:0] & SYSERR_EN_MASK;
        if (wr_en0 && cfg_be[2])
            next_st.smi_en = cfg_wdata[22:16];
        if (cfg_wr && hbe_hit(cfg_addr, OFF_SCI_EN) && cfg_be[0])
            next_st.sci_en = cfg_wdata[6:0];

        // write-once identifiers: any touched lane closes the field
        if (wr_sub && !st.vendor_locked && (cfg_be[1:0] != 2'b00)) begin
            if (cfg_be[0]) next_st.subsys_vendor[7:0]  = cfg_wdata[7:0];
            if (cfg_be[1]) next_st.subsys_vendor[15:8] = cfg_wdata[15:8];
            next_st.vendor_locked = 1'b1;
        end
        if (wr_sub && !st.ident_locked && (cfg_be[3:2] != 2'b00)) begin
            if (cfg_be[2]) next_st.subsys_ident[7:0]  = cfg_wdata[23:16];
            if (cfg_be[3]) next_st.subsys_ident[15:8] = cfg_wdata[31:24];
            next_st.ident_locked = 1'b1;
        end

        // one request per newly set enabled flag group
        next_st.syserr_msg = st.global_syserr && |(new_flags & st.syserr_en);
        next_st.smi_msg    = |(new_flags & st.smi_en);
        next_st.sci_msg    = |(new_flags & st.sci_en);

        if (wr_cmd && cfg_be[3] && cfg_wdata[16 + POS_SIGNALED_SERR])
            next_st.signaled_syserr = 1'b0;
        if (st.syserr_msg)
            next_st.signaled_syserr = 1'b1;

        next_st.rvalid = cfg_rd;
        if (cfg_rd)
            next_st.rdata = rd_word;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st               <= '0;
            st.subsys_vendor <= RST_SUBSYS;
            st.subsys_ident  <= RST_SUBSYS;
            st.rdata         <= RST_RDATA;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign cfg_rdata  = st.rdata;
    assign cfg_rvalid = st.rvalid;
    assign syserr_msg = st.syserr_msg;
    assign smi_msg    = st.smi_msg;
    assign sci_msg    = st.sci_msg;

endmodule // hbe_regs

// File: verification/hbe_hub_model.sv
// link-B hub model raising fault indications
`timescale 1ns/1ps
module hbe_hub_model (
    // clock
    input wire logic       clk,
    // fault lines
    output logic     [6:0] err_event
);
    initial err_event = 7'h00;
    // one-cycle fault pulse, changed away from the sampling edge
    task automatic fire(input logic [6:0] bits);
        @(negedge clk);
        err_event = bits;
        @(negedge clk);
        err_event = 7'h00;
    endtask
endmodule // hbe_hub_model

// File: verification/hbe_regs_monitor.sv
// checker for the link-B error register bank ports
`timescale 1ns/1ps
module hbe_regs_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    // config port
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [7:2]  cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_rvalid,
    // faults and messages
    input wire logic [6:0]  err_event,
    input wire logic        syserr_msg,
    input wire logic        smi_msg,
    input wire logic        sci_msg
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ===========================================
    // shadow of the global enable and last read dword
    logic       gse;
    logic [7:2] ra;
    always_ff @(posedge clk) begin
        if (rst)
            gse <= 1'b0;
        else if (ce && cfg_wr && cfg_addr == 6'h01 && cfg_be[1])
            gse <= cfg_wdata[8];
    end
    always_ff @(posedge clk) begin
        if (rst)
            ra <= 6'h00;
        else if (ce && cfg_rd)
            ra <= cfg_addr;
    end
    // ===========================================
    // assertions
    property p_ans; ce && cfg_rd |=> cfg_rvalid; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_one; cfg_rvalid && ra == 6'h20 |-> $onehot0(cfg_rdata[6:0]); endproperty
    a_one: assert property (p_one) else $error("first error not one-hot");
    property p_r80; cfg_rvalid && ra == 6'h20 |-> (cfg_rdata & 32'hFF80_FF80) == 0; endproperty
    a_r80: assert property (p_r80) else $error("error reserved bits set");
    property p_cls; cfg_rvalid && ra == 6'h02 |-> cfg_rdata[31:8] == 24'hFF_0000; endproperty
    a_cls: assert property (p_cls) else $error("class code wrong");
    property p_sts; cfg_rvalid && ra == 6'h01 |-> (cfg_rdata & 32'hBFFF_FEFF) == 0; endproperty
    a_sts: assert property (p_sts) else $error("status reserved bits set");
    property p_hdr; cfg_rvalid && ra == 6'h03 |-> cfg_rdata[23:16] inside {8'h00, 8'h80}; endproperty
    a_hdr: assert property (p_hdr) else $error("header type wrong");
    property p_gate; syserr_msg |-> $past(gse); endproperty
    a_gate: assert property (p_gate) else $error("system error while disabled");
    property p_cause; $past(ce) && (syserr_msg || smi_msg || sci_msg) |-> $past(err_event) != 0; endproperty
    a_cause: assert property (p_cause) else $error("message without fault");
endmodule // hbe_regs_monitor

// File: verification/tb.sv
// self-checking bench for the link-B error register bank
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        cfg_wr = 1'b0;
    logic        cfg_rd = 1'b0;
    logic [7:2]  cfg_addr = 6'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic [31:0] cfg_rdata;
    logic        cfg_rvalid;
    logic [2:0]  msg;
    logic [6:0]  err_event;
    int          n_errors = 0;
    int          num_checks = 0;
    always #2.5 clk = ~clk;
    hbe_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .err_event(err_event), .syserr_msg(msg[2]),
        .smi_msg(msg[1]), .sci_msg(msg[0]));
    hbe_hub_model hub_u (.clk(clk), .err_event(err_event));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = off[7:2];
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    // a missing answer is turned into a guaranteed mismatch
    task automatic rd(input logic [7:0] off, input logic [31:0] exp);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = off[7:2];
        @(negedge clk);
        cfg_rd = 1'b0;
        chk(cfg_rvalid === 1'b1 ? cfg_rdata : ~exp, exp);
    endtask
    task automatic ev(input logic [6:0] bits, input logic [2:0] m);
        hub_u.fire(bits);
        chk({29'h0, msg}, {29'h0, m});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // whole run is about 130 cycles; this leaves wide margin
    initial begin
        #50000;
        n_errors++;
        wrap_up;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        wr(8'h00, 4'hF, 32'hFFFF_FFFF);
        wr(8'h08, 4'hF, 32'hFFFF_FFFF);
        wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
        rd(8'h00, 32'h5678_1234);
        rd(8'h08, 32'hFF00_0001);
        rd(8'h0C, 32'h0080_0000);
        rd(8'h40, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        $display("constants test done");
        wr(8'h2C, 4'h3, 32'h0000_BEEF);
        wr(8'h2C, 4'hF, 32'h1111_1111);
        rd(8'h2C, 32'h1111_BEEF);
        wr(8'h2C, 4'hC, 32'h2222_0000);
        rd(8'h2C, 32'h1111_BEEF);
        $display("subsystem test done");
        wr(8'hA0, 4'hF, 32'hFFFF_FFFF);
        rd(8'hA0, 32'h007F_003F);
        wr(8'hA0, 4'hF, 32'h0000_003F);
        ev(7'h20, 3'b000);
        rd(8'h80, 32'h0000_0020);
        ev(7'h10, 3'b000);
        rd(8'h80, 32'h0010_0020);
        wr(8'h80, 4'hF, 32'h0000_0000);
        rd(8'h80, 32'h0010_0020);
        wr(8'h80, 4'hF, 32'h0010_0020);
        rd(8'h80, 32'h0000_0000);
        wr(8'h04, 4'h3, 32'h0000_0100);
        ev(7'h01, 3'b100);
        rd(8'h04, 32'h4000_0100);
        wr(8'h04, 4'hC, 32'h4000_0000);
        rd(8'h04, 32'h0000_0100);
        wr(8'h80, 4'hF, 32'h0000_0001);
        $display("system error test done");
        wr(8'hA0, 4'hF, 32'h0000_0000);
        wr(8'hA4, 4'hF, 32'h0000_007F);
        for (int i = 0; i < 7; i++) begin
            ev(7'h01 << i, 3'b001);
            rd(8'h80, 32'h0000_0001 << i);
            wr(8'h80, 4'hF, 32'h0000_0001 << i);
        end
        ev(7'h05, 3'b001);
        rd(8'h80, 32'h0001_0004);
        wr(8'h80, 4'hF, 32'h0001_0004);
        wr(8'hA4, 4'hF, 32'h0000_0000);
        wr(8'hA0, 4'hF, 32'h007F_0000);
        ev(7'h40, 3'b010);
        rd(8'h80, 32'h0000_0040);
        wr(8'h80, 4'hF, 32'h0000_0040);
        // a fault while the clock enable is low must leave no trace
        @(negedge clk);
        ce = 1'b0;
        hub_u.fire(7'h01);
        ce = 1'b1;
        rd(8'h80, 32'h0000_0000);
        $display("flag test done");
        wrap_up;
    end
endmodule // tb
bind hbe_regs hbe_regs_monitor mon_u (.clk(clk), .rst(rst), .ce(ce), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .err_event(err_event),
    .syserr_msg(syserr_msg), .smi_msg(smi_msg), .sci_msg(sci_msg));
